// ===== rtl/lpw_defines.svh
// Behaviour
// - Bus wake pattern in sleep: standby, interrupt.
// - Pattern is dominant, recessive, dominant, each filtered.
// - Phases advance unreset; complete on second dominant.
// - Only states longer than filter time count.
// - Select bit 0: hold receive line low.
// - Select bit 1: toggle receive line every period.
// - Normal mode or undervoltage drops wake request.
// - Pattern timeout: wait recessive, then restart.
// - Request after power up, sleep exit, wake.
// - Wake input edge: both, rising or falling.
// - Single edge needs settled opposite level first.
// - Pulse enable set: reject wake pulses shorter than reject time.
// - Pulse mode accepts widths between min and max.
// - Max disable turns pulse into filtered wake.
// - Direction bit picks pulse or filter polarity.
// - Latch wake edge status until software writes 00.
// - Local wake active except normal, listen, failsafe; wakes to standby.
// - Selective wake: frame receiver on, receive line quiet.
// - Selective wake exits only on listed events.
// - Frame or local wake: flag, line low, interrupt.
// - Selective wake needs configured, no error, enable.
// - Fault or overflow clears selective wake enable.
`ifndef LPW_DEFINES_SVH
`define LPW_DEFINES_SVH
// Clock period in nanoseconds.
`define LPW_CLK_NS 10
// Times in nanoseconds.
`define LPW_FILT_NS 1000
`define LPW_TIMEOUT_NS 1000000
`define LPW_TOGGLE_NS 10000
`define LPW_SETTLE_NS 50000
`define LPW_REJECT_NS 1000
`define LPW_PULSE_MAX_NS 100000
// Register offsets.
`define LPW_REG_MODE 8'h10
`define LPW_REG_WAKE 8'h11
`define LPW_REG_RXCFG 8'h12
`define LPW_REG_PULSE 8'h18
`define LPW_REG_FLAGS 8'h20
`define LPW_REG_INTEN 8'h21
`define LPW_REG_SEL_WAKE_CONFIGURED 8'h4F
// Field positions.
`define LPW_SEL_WAKE_ENABLE_BIT 7
`define LPW_RXD_SEL_BIT 2
`define LPW_DIR_BIT 7
`define LPW_PULSE_EN_BIT 6
`define LPW_MAX_DIS_BIT 1
`define LPW_SEL_WAKE_CONFIGURED_BIT 7
`define LPW_SEL_WAKE_ERROR_BIT 0
// Mode command codes.
`define LPW_CMD_STANDBY 3'h1
`define LPW_CMD_NORMAL 3'h2
`define LPW_CMD_LISTEN 3'h3
`define LPW_CMD_SLEEP 3'h4
// Edge selection codes.
`define LPW_EDGE_BOTH 2'h0
`define LPW_EDGE_RISE 2'h1
`define LPW_EDGE_FALL 2'h2
// Flag bit positions.
`define LPW_FL_BUS 0
`define LPW_FL_LOCAL 1
`define LPW_FL_FRAME 2
`define LPW_FL_OVF 3
`define LPW_FL_PWRON 4
`endif

// ===== rtl/lpw_pkg.sv
package lpw_pkg;
  // Operating modes of the device.
  typedef enum logic [2:0] {
    LPW_SLEEP, LPW_STANDBY, LPW_NORMAL, LPW_LISTEN, LPW_GOSLEEP, LPW_SELWAKE, LPW_FAILSAFE
  } lpw_mode_t;
  // Phases of the bus wake pattern detector.
  typedef enum logic [1:0] {PH_IDLE, PH_DOM1, PH_REC, PH_WAITREC} lpw_phase_t;
  // Whole state of the block.
  typedef struct packed {
    lpw_mode_t mode;
    lpw_phase_t phase;
    logic bus_lvl;
    logic [23:0] bus_cnt;
    logic [23:0] tmo_cnt;
    logic bus_req;
    logic tog;
    logic [23:0] tog_cnt;
    logic wake_lvl;
    logic [23:0] wake_cnt;
    logic [23:0] settle_cnt;
    logic filt_done;
    logic sel_wake_enable;
    logic sw_cfg;
    logic [7:0] wake_cfg;
    logic [7:0] rx_cfg;
    logic [7:0] pulse_cfg;
    logic [4:0] flags;
    logic [4:0] int_en;
    logic rxd;
    logic int_n;
    logic frame_rx_en;
    logic [7:0] rdata;
  } lpw_state_t;
endpackage

// ===== rtl/lpw_wake.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "lpw_defines.svh"
// Every wake time below is a cycle count of ref_clk.
module lpw_wake import lpw_pkg::*; #(
  parameter int FILT_CYC = (`LPW_FILT_NS + `LPW_CLK_NS - 1) / `LPW_CLK_NS,
  parameter int TIMEOUT_CYC = `LPW_TIMEOUT_NS / `LPW_CLK_NS,
  parameter int TOGGLE_CYC = `LPW_TOGGLE_NS / `LPW_CLK_NS,
  parameter int SETTLE_CYC = (`LPW_SETTLE_NS + `LPW_CLK_NS - 1) / `LPW_CLK_NS,
  parameter int REJECT_CYC = (`LPW_REJECT_NS + `LPW_CLK_NS - 1) / `LPW_CLK_NS,
  parameter int PULSE_MAX_CYC = `LPW_PULSE_MAX_NS / `LPW_CLK_NS
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Bus side and wake pin.
  input wire logic bus_dominant,
  input wire logic bus_rx,
  input wire logic wake_pin,
  // Frame detection and supervision.
  input wire logic wake_frame,
  input wire logic frame_overflow,
  input wire logic vcc_uv,
  input wire logic fault,
  // Host side.
  output logic rxd,
  output logic interrupt_out_n,
  output logic frame_rx_en
);

  // Counts must fit the 24-bit counters and never be zero.
  if (FILT_CYC < 1 || TIMEOUT_CYC < 1 || TOGGLE_CYC < 1 || SETTLE_CYC < 1 ||
      REJECT_CYC < 1 || PULSE_MAX_CYC <= 4 * REJECT_CYC || TIMEOUT_CYC > 24'hFFFFFF ||
      PULSE_MAX_CYC > 24'hFFFFFF || SETTLE_CYC > 24'hFFFFFF) begin : g_chk
    $error("lpw_wake: cycle count parameters out of range");
  end

  localparam logic [23:0] FILT_C = FILT_CYC[23:0];
  localparam logic [23:0] TMO_C = TIMEOUT_CYC[23:0];
  localparam logic [23:0] TOG_C = TOGGLE_CYC[23:0];
  localparam logic [23:0] SETTLE_C = SETTLE_CYC[23:0];
  localparam logic [23:0] REJECT_C = REJECT_CYC[23:0];
  localparam logic [23:0] PMAX_C = PULSE_MAX_CYC[23:0];

  // Saturating increment so a long idle level never wraps back to zero.
  function automatic logic [23:0] sat_inc(input logic [23:0] v);
    sat_inc = (v == 24'hFFFFFF) ? v : v + 24'h000001;
  endfunction

  // Reject time chosen by the two-bit setting: one to four base units.
  function automatic logic [23:0] reject_of(input logic [1:0] sel);
    reject_of = REJECT_C * ({22'h000000, sel} + 24'h000001);
  endfunction

  // Reset release through two flops; the first is read only by the second.
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  lpw_state_t s_q; // Registered state.
  lpw_state_t s_d; // Next state.

  // Combinational helpers.
  logic filt_evt; // Bus level has just become filtered.
  logic pat_done; // Whole pattern recognised this cycle.
  logic lw_active; // Local wake logic is listening.
  logic wk_edge; // Wake pin changed this cycle.
  logic wk_rise; // The change was a rising one.
  logic edge_ok; // Edge direction allowed by configuration.
  logic local_wake_event; // Valid local wake this cycle.
  logic [23:0] rej; // Current reject width.
  logic pulse_lvl; // Level that forms a pulse.
  logic wr_mode; // Mode register write.
  logic [2:0] cmd; // Mode command written.
  logic wake_evt; // Any wake out of a low-power mode.

  always_comb begin
    s_d = s_q;
    // Bus level filter: an event once the level has stood longer than the filter time.
    filt_evt = 1'b0;
    pat_done = 1'b0;
    if (bus_dominant != s_q.bus_lvl) begin
      s_d.bus_lvl = bus_dominant;
      s_d.bus_cnt = 24'h000000;
    end else begin
      s_d.bus_cnt = sat_inc(s_q.bus_cnt);
      filt_evt = (s_q.bus_cnt == FILT_C);
    end

    // Pattern detector runs in sleep and selective wake; other traffic leaves phases alone.
    if (s_q.mode == LPW_SLEEP || s_q.mode == LPW_SELWAKE) begin
      if (s_q.phase == PH_DOM1 || s_q.phase == PH_REC) begin
        s_d.tmo_cnt = sat_inc(s_q.tmo_cnt);
      end
      unique case (s_q.phase)
        PH_IDLE: begin
          s_d.tmo_cnt = 24'h000000;
          if (filt_evt && s_q.bus_lvl) begin
            s_d.phase = PH_DOM1;
          end
        end
        PH_DOM1: begin
          if (s_q.tmo_cnt >= TMO_C) begin
            s_d.phase = PH_WAITREC;
          end else if (filt_evt && !s_q.bus_lvl) begin
            s_d.phase = PH_REC;
          end
        end
        PH_REC: begin
          if (s_q.tmo_cnt >= TMO_C) begin
            s_d.phase = PH_WAITREC;
          end else if (filt_evt && s_q.bus_lvl) begin
            pat_done = 1'b1;
            s_d.phase = PH_IDLE;
          end
        end
        PH_WAITREC: begin
          // After a timeout only a fresh recessive rearms the detector.
          if (filt_evt && !s_q.bus_lvl) begin
            s_d.phase = PH_IDLE;
          end
        end
      endcase
    end else begin
      s_d.phase = PH_IDLE;
      s_d.tmo_cnt = 24'h000000;
    end

    // Local wake on the wake pin.
    lw_active = (s_q.mode == LPW_SLEEP || s_q.mode == LPW_STANDBY ||
                 s_q.mode == LPW_GOSLEEP || s_q.mode == LPW_SELWAKE);
    wk_edge = (wake_pin != s_q.wake_lvl);
    wk_rise = wake_pin;
    rej = reject_of(s_q.wake_cfg[3:2]);
    pulse_lvl = s_q.rx_cfg[`LPW_DIR_BIT];
    local_wake_event = 1'b0;
    unique case (s_q.wake_cfg[7:6])
      `LPW_EDGE_RISE: edge_ok = wk_rise && s_q.settle_cnt >= SETTLE_C;
      `LPW_EDGE_FALL: edge_ok = !wk_rise && s_q.settle_cnt >= SETTLE_C;
      default: edge_ok = 1'b1;
    endcase
    if (wk_edge) begin
      s_d.wake_lvl = wake_pin;
      s_d.wake_cnt = 24'h000000;
      s_d.settle_cnt = 24'h000000;
      s_d.filt_done = 1'b0;
      // Edge status latches in any mode; a clear in the same cycle keeps only this edge's bit.
      s_d.wake_cfg[5:4] = s_q.wake_cfg[5:4] | {wk_rise, !wk_rise};
    end else begin
      s_d.wake_cnt = sat_inc(s_q.wake_cnt);
      s_d.settle_cnt = sat_inc(s_q.settle_cnt);
    end
    if (lw_active) begin
      if (!s_q.rx_cfg[`LPW_PULSE_EN_BIT]) begin
        local_wake_event = wk_edge && edge_ok;
      end else if (s_q.pulse_cfg[`LPW_MAX_DIS_BIT]) begin
        // Filtered wake: level held past the minimum width wakes at once.
        local_wake_event = !wk_edge && s_q.wake_lvl == pulse_lvl && !s_q.filt_done &&
              s_q.wake_cnt == rej;
        if (local_wake_event) begin
          s_d.filt_done = 1'b1;
        end
      end else begin
        // Pulse wake: judged on the trailing edge by the pulse's width.
        local_wake_event = wk_edge && s_q.wake_lvl == pulse_lvl && s_q.wake_cnt >= rej &&
              s_q.wake_cnt <= PMAX_C;
      end
    end

    // Register writes.
    wr_mode = reg_wr && reg_addr == `LPW_REG_MODE;
    cmd = reg_wdata[2:0];
    if (reg_wr) begin
      unique case (reg_addr)
        `LPW_REG_MODE: s_d.sel_wake_enable = reg_wdata[`LPW_SEL_WAKE_ENABLE_BIT];
        `LPW_REG_WAKE: begin
          s_d.wake_cfg[7:6] = reg_wdata[7:6];
          s_d.wake_cfg[3:2] = reg_wdata[3:2];
          if (reg_wdata[5:4] == 2'h0) begin
            s_d.wake_cfg[5:4] = wk_edge ? {wk_rise, !wk_rise} : 2'h0;
          end
        end
        `LPW_REG_RXCFG: s_d.rx_cfg = reg_wdata;
        `LPW_REG_PULSE: s_d.pulse_cfg = reg_wdata;
        `LPW_REG_FLAGS: s_d.flags = s_q.flags & ~reg_wdata[4:0];
        `LPW_REG_INTEN: s_d.int_en = reg_wdata[4:0];
        `LPW_REG_SEL_WAKE_CONFIGURED: s_d.sw_cfg = reg_wdata[`LPW_SEL_WAKE_CONFIGURED_BIT];
        default: ;
      endcase
    end

    // Mode sequencing.
    wake_evt = 1'b0;
    unique case (s_q.mode)
      LPW_GOSLEEP: begin
        s_d.settle_cnt = 24'h000000; // Settling restarts at sleep entry.
        if (s_q.sw_cfg && !s_q.flags[`LPW_FL_OVF] && s_q.sel_wake_enable) begin
          s_d.mode = LPW_SELWAKE;
        end else begin
          s_d.mode = LPW_SLEEP;
        end
      end
      LPW_SLEEP: begin
        if (pat_done || local_wake_event) begin
          s_d.mode = LPW_STANDBY;
          wake_evt = 1'b1;
        end
      end
      LPW_SELWAKE: begin
        if (frame_overflow) begin
          s_d.mode = LPW_SLEEP;
        end else if (wake_frame || local_wake_event) begin
          s_d.mode = LPW_STANDBY;
          wake_evt = 1'b1;
        end
      end
      LPW_STANDBY: begin
        if (local_wake_event) begin
          wake_evt = 1'b1;
        end
      end
      default: ;
    endcase
    if (wr_mode) begin
      unique case (cmd)
        `LPW_CMD_STANDBY: s_d.mode = LPW_STANDBY;
        `LPW_CMD_NORMAL: s_d.mode = LPW_NORMAL;
        `LPW_CMD_LISTEN: s_d.mode = LPW_LISTEN;
        `LPW_CMD_SLEEP: s_d.mode = LPW_GOSLEEP;
        default: ;
      endcase
    end
    if (fault) begin
      s_d.mode = LPW_FAILSAFE;
      s_d.sel_wake_enable = 1'b0;
    end
    if (s_q.mode == LPW_SELWAKE && frame_overflow) begin
      s_d.sel_wake_enable = 1'b0;
    end

    // Wake flags; a hardware set wins over a software clear.
    if (pat_done && s_q.mode == LPW_SLEEP) begin
      s_d.flags[`LPW_FL_BUS] = 1'b1;
    end
    if (local_wake_event) begin
      s_d.flags[`LPW_FL_LOCAL] = 1'b1;
    end
    if (s_q.mode == LPW_SELWAKE && wake_frame) begin
      s_d.flags[`LPW_FL_FRAME] = 1'b1;
    end
    if (s_q.mode == LPW_SELWAKE && frame_overflow) begin
      s_d.flags[`LPW_FL_OVF] = 1'b1;
    end

    // Bus wake request on the receive line.
    if (wake_evt) begin
      s_d.bus_req = 1'b1;
    end else if (wr_mode && cmd == `LPW_CMD_STANDBY) begin
      s_d.bus_req = 1'b0;
    end
    if ((wr_mode && (cmd == `LPW_CMD_NORMAL || cmd == `LPW_CMD_LISTEN)) || vcc_uv) begin
      s_d.bus_req = 1'b0;
    end
    if (s_d.bus_req && !s_q.bus_req) begin
      s_d.tog = 1'b0;
      s_d.tog_cnt = 24'h000000;
    end else if (s_q.tog_cnt >= TOG_C - 24'h000001) begin
      s_d.tog = !s_q.tog;
      s_d.tog_cnt = 24'h000000;
    end else begin
      s_d.tog_cnt = s_q.tog_cnt + 24'h000001;
    end
    if (s_q.mode == LPW_NORMAL || s_q.mode == LPW_LISTEN) begin
      s_d.rxd = bus_rx;
    end else if (s_q.bus_req) begin
      s_d.rxd = s_q.rx_cfg[`LPW_RXD_SEL_BIT] ? s_q.tog : 1'b0;
    end else begin
      s_d.rxd = 1'b1;
    end
    s_d.frame_rx_en = (s_q.mode == LPW_SELWAKE);
    s_d.int_n = ~|(s_q.flags & s_q.int_en);

    // Read data stands in the cycle after the strobe.
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `LPW_REG_MODE: s_d.rdata = {s_q.sel_wake_enable, 4'h0, s_q.mode};
        `LPW_REG_WAKE: s_d.rdata = {s_q.wake_cfg[7:2], 2'h0};
        `LPW_REG_RXCFG: s_d.rdata = s_q.rx_cfg;
        `LPW_REG_PULSE: s_d.rdata = s_q.pulse_cfg;
        `LPW_REG_FLAGS: s_d.rdata = {3'h0, s_q.flags};
        `LPW_REG_INTEN: s_d.rdata = {3'h0, s_q.int_en};
        `LPW_REG_SEL_WAKE_CONFIGURED: s_d.rdata = {s_q.sw_cfg, 6'h00, s_q.flags[`LPW_FL_OVF]};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // State register; power up lands in standby with the request active.
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '{mode: LPW_STANDBY, phase: PH_IDLE, bus_lvl: 1'b0, bus_cnt: 24'h000000,
               tmo_cnt: 24'h000000, bus_req: 1'b1, tog: 1'b0, tog_cnt: 24'h000000,
               wake_lvl: 1'b0, wake_cnt: 24'h000000, settle_cnt: 24'h000000,
               filt_done: 1'b0, sel_wake_enable: 1'b0, sw_cfg: 1'b0, wake_cfg: 8'h00,
               rx_cfg: 8'h00, pulse_cfg: 8'h00, flags: 5'h10, int_en: 5'h00,
               rxd: 1'b1, int_n: 1'b1, frame_rx_en: 1'b0, rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign rxd = s_q.rxd;
  assign interrupt_out_n = s_q.int_n;
  assign frame_rx_en = s_q.frame_rx_en;
endmodule

// ===== test/lpw_wake_sva.sv
`timescale 1ns/1ps
module lpw_wake_sva #(
  parameter int TOGGLE_CYC = 1000
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Bus side, wake pin and supervision.
  input wire logic bus_dominant,
  input wire logic bus_rx,
  input wire logic wake_pin,
  input wire logic wake_frame,
  input wire logic frame_overflow,
  input wire logic vcc_uv,
  input wire logic fault,
  // Host side.
  input wire logic rxd,
  input wire logic interrupt_out_n,
  input wire logic frame_rx_en
);
  // Mirrors of written settings; device-side clearing is not mirrored except norm_q on fault, which only weakens checks.
  logic norm_q, sel_q, swen_q, sel_wake_configured_q, im_q, ienv_q, blk_q, rxd_p_q;
  logic [4:0] ien_q;
  logic [15:0] gap_q;
  logic [3:0] slp_q;
  logic mode_wr;
  assign mode_wr = reg_wr && (reg_addr == 8'h10) && (reg_wdata[2:0] != 3'h0);
  // Track modes and settings, and count cycles between receive-line changes.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {norm_q, sel_q, swen_q, sel_wake_configured_q, im_q, ienv_q, blk_q} <= 7'h00;
      rxd_p_q <= 1'b1;
      ien_q <= 5'h00;
      gap_q <= 16'h0000;
      slp_q <= 4'hF;
    end else begin
      if (mode_wr) begin
        norm_q <= (reg_wdata[2:0] == 3'h2) || (reg_wdata[2:0] == 3'h3);
        swen_q <= reg_wdata[7];
      end else if (fault) begin
        norm_q <= 1'b0;
      end
      if (reg_wr && reg_addr == 8'h12) begin
        sel_q <= reg_wdata[2];
      end
      if (reg_wr && reg_addr == 8'h4F) begin
        sel_wake_configured_q <= reg_wdata[7];
      end
      if (reg_wr && reg_addr == 8'h21) begin
        ien_q <= reg_wdata[4:0];
        ienv_q <= 1'b1;
      end
      im_q <= ienv_q && (ien_q == 5'h00);
      blk_q <= reg_wr || vcc_uv || fault;
      slp_q <= (mode_wr && reg_wdata[2:0] == 3'h4) ? 4'h0 : ((slp_q == 4'hF) ? slp_q : slp_q + 4'h1);
      rxd_p_q <= rxd;
      gap_q <= (rxd != rxd_p_q) ? 16'h0001 : ((gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001);
    end
  end
  a_rx_pass: assert property (@(posedge ref_clk) disable iff (!nrst)
    norm_q && $past(norm_q) |-> rxd == $past(bus_rx)) else $error("rxd not following bus");
  a_req_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !sel_q && !norm_q && !rxd && !reg_wr && !vcc_uv && !fault && !blk_q |=> !rxd)
    else $error("held wake request released");
  a_toggle_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel_q && !norm_q && !blk_q && !reg_wr && rxd && !rxd_p_q |-> gap_q == TOGGLE_CYC)
    else $error("toggle period wrong");
  a_uv_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(vcc_uv) && !norm_q |-> ##2 rxd) else $error("undervoltage kept request");
  a_int_masked: assert property (@(posedge ref_clk) disable iff (!nrst)
    im_q |-> interrupt_out_n) else $error("interrupt low while masked");
  a_sel_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(frame_rx_en) |-> swen_q && sel_wake_configured_q && slp_q <= 4'h4) else $error("bad entry");
  a_sel_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    frame_rx_en && $past(frame_rx_en) && !$past(wake_frame) && !$past(wake_frame, 2)
    |-> $stable(rxd)) else $error("rxd moved in selective wake");
  a_ovf_exit: assert property (@(posedge ref_clk) disable iff (!nrst)
    frame_rx_en && frame_overflow |-> ##[1:3] !frame_rx_en) else $error("overflow ignored");
  a_frame_wake: assert property (@(posedge ref_clk) disable iff (!nrst)
    frame_rx_en && wake_frame |-> ##[1:6] (!rxd && !frame_rx_en)) else $error("no frame wake");
endmodule
bind lpw_wake lpw_wake_sva #(.TOGGLE_CYC(TOGGLE_CYC)) i_lpw_wake_sva (.ref_clk(ref_clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bus_dominant(bus_dominant), .bus_rx(bus_rx), .wake_pin(wake_pin),
  .wake_frame(wake_frame), .frame_overflow(frame_overflow), .vcc_uv(vcc_uv), .fault(fault),
  .rxd(rxd), .interrupt_out_n(interrupt_out_n), .frame_rx_en(frame_rx_en));

// ===== test/lpw_host_model.sv
`timescale 1ns/1ps
module lpw_host_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Receive line from the device.
  input wire logic rxd,
  // Falling steps seen on the receive line.
  output logic [7:0] falls
);
  // Last level seen; a controller reacts only to the high-to-low step.
  logic rxd_q;
  // Count each wake request step, as the controller would on its wake monitor.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxd_q <= 1'b1;
      falls <= 8'h00;
    end else begin
      rxd_q <= rxd;
      if (rxd_q && !rxd) begin
        falls <= falls + 8'h01;
      end
    end
  end
endmodule

// ===== test/test_low_power_wake_detection.sv
`timescale 1ns/1ps
module test_low_power_wake_detection;
  // Short counts keep the run brief; all expectations follow from them.
  localparam int TOG = 10;
  logic ref_clk, nrst, reg_wr, reg_rd, bus_dominant, bus_rx, wake_pin;
  logic wake_frame, frame_overflow, vcc_uv, fault, rxd, interrupt_out_n, frame_rx_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, falls, f0;
  int fail_count, tests_run;
  int pw[3] = '{1, 30, 5};
  logic [7:0] pm[3] = '{8'h00, 8'h00, 8'h01};
  lpw_wake #(.FILT_CYC(4), .TIMEOUT_CYC(200), .TOGGLE_CYC(TOG), .SETTLE_CYC(8),
    .REJECT_CYC(2), .PULSE_MAX_CYC(20)) i_lpw_wake (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_dominant(bus_dominant), .bus_rx(bus_rx), .wake_pin(wake_pin),
    .wake_frame(wake_frame), .frame_overflow(frame_overflow), .vcc_uv(vcc_uv), .fault(fault),
    .rxd(rxd), .interrupt_out_n(interrupt_out_n), .frame_rx_en(frame_rx_en));
  lpw_host_model i_lpw_host_model (.ref_clk(ref_clk), .nrst(nrst), .rxd(rxd), .falls(falls));
  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic end_sim;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe; the register takes the value at the next edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask
  task automatic bus(input logic v, input int n);
    @(posedge ref_clk);
    bus_dominant <= v;
    cyc(n - 1);
  endtask
  task automatic pin(input logic v, input int n);
    @(posedge ref_clk);
    wake_pin <= v;
    cyc(n - 1);
  endtask
  // Standby first drops any request, then flags are cleared before going to sleep.
  task automatic slp(input logic [7:0] cmd);
    wr(8'h10, 8'h01);
    wr(8'h20, 8'h1F);
    wr(8'h10, cmd);
    cyc(3);
  endtask
  task automatic bus_wake_pattern;
    bus(1'b1, 6);
    bus(1'b0, 6);
    bus(1'b1, 6);
    bus(1'b0, 3);
  endtask
  // Watchdog sized well above the expected run of under a thousand cycles.
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
  // Main sequence.
  initial begin
    {nrst, reg_wr, reg_rd, bus_dominant, bus_rx, wake_pin} = 6'h00;
    {wake_frame, frame_overflow, vcc_uv, fault, reg_addr, reg_wdata} = 20'h00000;
    fail_count = 0;
    tests_run = 0;
    cyc(4);
    nrst <= 1'b1;
    cyc(4);
    rd(8'h10, 8'h07, 8'h01);
    rd(8'h20, 8'h10, 8'h10);
    chk({7'h0, rxd}, 8'h00);
    rd(8'h33, 8'hFF, 8'h00);
    wr(8'h21, 8'h1F);
    $display("test power-up done");
    slp(8'h04);
    chk({7'h0, rxd}, 8'h01);
    bus(1'b1, 4);
    bus(1'b0, 4);
    bus(1'b1, 4);
    bus(1'b0, 8);
    rd(8'h10, 8'h07, 8'h00);
    bus(1'b1, 6);
    bus(1'b0, 3);
    bus(1'b1, 2);
    bus_wake_pattern();
    rd(8'h10, 8'h07, 8'h01);
    rd(8'h20, 8'h01, 8'h01);
    chk({6'h0, rxd, interrupt_out_n}, 8'h00);
    @(posedge ref_clk);
    vcc_uv <= 1'b1;
    cyc(4);
    chk({7'h0, rxd}, 8'h01);
    vcc_uv <= 1'b0;
    $display("test bus wake done");
    slp(8'h04);
    bus(1'b1, 6);
    bus(1'b0, 250);
    bus(1'b1, 6);
    bus(1'b0, 6);
    rd(8'h10, 8'h07, 8'h00);
    bus_wake_pattern();
    rd(8'h10, 8'h07, 8'h01);
    $display("test timeout done");
    wr(8'h12, 8'h04);
    slp(8'h04);
    f0 = falls;
    bus_wake_pattern();
    cyc(4 * TOG + 5);
    chk({7'h0, (falls - f0) >= 8'h02}, 8'h01);
    wr(8'h10, 8'h02);
    for (int i = 0; i < 2; i++) begin
      bus_rx <= i[0];
      cyc(3);
      chk({7'h0, rxd}, {7'h0, i[0]});
    end
    wr(8'h10, 8'h03);
    rd(8'h10, 8'h07, 8'h03);
    wr(8'h12, 8'h00);
    $display("test toggle done");
    wr(8'h11, 8'h00);
    slp(8'h04);
    pin(1'b1, 3);
    rd(8'h10, 8'h07, 8'h01);
    rd(8'h20, 8'h02, 8'h02);
    @(posedge ref_clk);
    #1;
    chk({7'h0, reg_rdata === 8'h00}, 8'h01);
    rd(8'h11, 8'h30, 8'h20);
    wr(8'h11, 8'h40);
    rd(8'h11, 8'h30, 8'h00);
    slp(8'h04);
    pin(1'b0, 3);
    pin(1'b1, 3);
    rd(8'h10, 8'h07, 8'h00);
    pin(1'b0, 12);
    pin(1'b1, 3);
    rd(8'h10, 8'h07, 8'h01);
    wr(8'h11, 8'h80);
    slp(8'h04);
    pin(1'b0, 3);
    rd(8'h10, 8'h07, 8'h00);
    pin(1'b1, 12);
    pin(1'b0, 3);
    rd(8'h10, 8'h07, 8'h01);
    $display("test wake pin edges done");
    wr(8'h11, 8'h00);
    wr(8'h12, 8'hC0);
    for (int i = 0; i < 3; i++) begin
      slp(8'h04);
      pin(1'b1, pw[i]);
      pin(1'b0, 3);
      rd(8'h10, 8'h07, pm[i]);
    end
    wr(8'h18, 8'h02);
    slp(8'h04);
    pin(1'b1, 5);
    rd(8'h10, 8'h07, 8'h01);
    pin(1'b0, 3);
    wr(8'h18, 8'h00);
    wr(8'h12, 8'h00);
    $display("test wake pulses done");
    wr(8'h4F, 8'h80);
    rd(8'h4F, 8'h80, 8'h80);
    slp(8'h84);
    chk({7'h0, frame_rx_en}, 8'h01);
    for (int i = 0; i < 2; i++) begin
      bus_rx <= i[0];
      cyc(3);
      chk({7'h0, rxd}, 8'h01);
    end
    wake_frame <= 1'b1;
    cyc(2);
    wake_frame <= 1'b0;
    cyc(4);
    rd(8'h10, 8'h07, 8'h01);
    rd(8'h20, 8'h04, 8'h04);
    chk({7'h0, rxd}, 8'h00);
    slp(8'h84);
    frame_overflow <= 1'b1;
    cyc(1);
    frame_overflow <= 1'b0;
    cyc(4);
    rd(8'h10, 8'h87, 8'h00);
    wr(8'h10, 8'h81);
    fault <= 1'b1;
    cyc(3);
    rd(8'h10, 8'h87, 8'h06);
    fault <= 1'b0;
    wr(8'h10, 8'h01);
    wr(8'h21, 8'h00);
    cyc(3);
    chk({7'h0, interrupt_out_n}, 8'h01);
    $display("test selective wake done");
    end_sim();
  end
endmodule
